//--- src/qbr_read_port.sv
// burst-of-four dual-rate sram port: command latch, read pipeline, write burst
// assumes all inputs synchronous to sys_clk; one sys_clk cycle is one input half-cycle
`timescale 1ns/1ps
module qbr_read_port (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire qbr_pkg::qbr_cmd_t              cmd,
   input  wire qbr_pkg::qbr_wr_beat_t          wr_beat,
   input  wire logic                           out_clk,
   input  wire logic                           out_clk_n,
   output      logic                           k_clk,
   output      logic                           k_clk_n,
   output      logic                           read_slot,
   output      logic [qbr_pkg::QBR_DATA_W-1:0] read_data_out,
   output      logic                           read_data_oe
);
   import qbr_pkg::*;

   logic                  k_phase_r;
   logic                  slot_r;
   logic                  c_q_r;
   logic                  cn_q_r;
   logic                  rd_pend_r;
   logic [QBR_ADDR_W-1:0] rd_pend_addr_r;
   logic [QBR_ADDR_W-1:0] rd_base_r;
   logic [1:0]            rd_idx_r;
   logic [1:0]            rd_idx_nxt;
   qbr_rd_state_t         rd_state_r;
   qbr_rd_state_t         rd_state_nxt;
   logic [QBR_DATA_W-1:0] read_data_out_r;
   logic                  read_data_oe_r;
   logic                  read_data_oe_nxt;
   logic                  wr_pend_r;
   logic [QBR_ADDR_W-1:0] wr_pend_addr_r;
   logic [QBR_ADDR_W-1:0] wr_base_r;
   logic [1:0]            wr_idx_r;
   qbr_wr_state_t         wr_state_r;
   qbr_wr_state_t         wr_state_nxt;

   wire k_rise  = ~k_phase_r;
   wire rd_slot = k_rise & ~slot_r;
   wire wr_slot = k_rise & slot_r;

   // output clock edge detect; inputs are already synchronous, so no synchroniser
   wire c_rise      = out_clk & ~c_q_r;
   wire cn_rise     = out_clk_n & ~cn_q_r;
   // both output clocks held high for two samples selects single-clock mode
   wire single_mode = out_clk & out_clk_n & c_q_r & cn_q_r;
   wire strobe_t    = single_mode ? k_rise : c_rise;
   wire strobe_c    = single_mode ? ~k_rise : cn_rise;

   // read request taken at a read slot with select low
   wire rd_req  = rd_slot & ~cmd.read_sel_n;
   // pending read moves into the output engine at a true input edge
   wire rd_move = k_rise & rd_pend_r & (rd_state_r != QBR_RD_BURST);
   // a new read is ignored while the pending slot is still occupied
   wire rd_take = rd_req & (~rd_pend_r | rd_move);

   // effective burst view: a moving read can launch its first word at once
   wire                  rd_active   = (rd_state_r == QBR_RD_BURST) | rd_move;
   wire [1:0]            rd_idx_eff  = rd_move ? QBR_FIRST_BEAT : rd_idx_r;
   wire [QBR_ADDR_W-1:0] rd_base_eff = rd_move ? rd_pend_addr_r : rd_base_r;
   // two-bit linear burst address on the read side
   wire [QBR_ADDR_W-1:0] rd_addr_eff = qbr_burst_addr(rd_base_eff, rd_idx_eff);
   // even words on the true edge, odd words on the complement edge
   wire                  launch      = rd_active & (rd_idx_eff[0] ? strobe_c : strobe_t);
   wire                  rd_last     = launch & (rd_idx_eff == QBR_LAST_BEAT);

   // write request depends only on the write select and the write slot
   wire wr_req  = wr_slot & ~cmd.write_sel_n;
   wire wr_move = k_rise & wr_pend_r & (wr_state_r != QBR_WR_BURST);
   wire wr_take = wr_req & (~wr_pend_r | wr_move);

   // one write beat every half-cycle while the burst runs
   wire                  wr_en       = (wr_state_r == QBR_WR_BURST) | wr_move;
   wire [1:0]            wr_idx_eff  = wr_move ? QBR_FIRST_BEAT : wr_idx_r;
   wire [QBR_ADDR_W-1:0] wr_base_eff = wr_move ? wr_pend_addr_r : wr_base_r;
   wire [QBR_ADDR_W-1:0] wr_addr     = qbr_burst_addr(wr_base_eff, wr_idx_eff);
   wire                  wr_last     = wr_en & (wr_idx_eff == QBR_LAST_BEAT);

   // lane mask from the active-low lane enables
   wire [3:0] lane_en_all = ~{wr_beat.lane3_write_enable_n, wr_beat.lane2_write_enable_n,
                              wr_beat.lane1_write_enable_n, wr_beat.lane0_write_enable_n};
   wire [QBR_LANES-1:0] wr_lane_mask = lane_en_all[QBR_LANES-1:0];

   wire [QBR_DATA_W-1:0] rd_data;

   // storage shared by both ports
   qbr_sram_array u_array (
      .sys_clk      (sys_clk),
      .wr_en        (wr_en),
      .wr_addr      (wr_addr),
      .wr_lane_mask (wr_lane_mask),
      .wr_data      (wr_beat.write_data_in),
      .rd_addr      (rd_addr_eff),
      .rd_data      (rd_data)
   );

   // input clock pair: phase and slot counters, output clock history
   // history starts at the tied-high level, so no false output clock edge follows reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         k_phase_r <= 1'b0;
         slot_r    <= 1'b0;
         c_q_r     <= 1'b1;
         cn_q_r    <= 1'b1;
      end else begin
         k_phase_r <= ~k_phase_r;
         slot_r    <= slot_r ^ k_rise;
         c_q_r     <= out_clk;
         cn_q_r    <= out_clk_n;
      end
   end

   // read engine next state: burst, then a tail until the next true input edge
   always_comb begin
      rd_state_nxt = rd_state_r;
      unique case (rd_state_r)
         QBR_RD_IDLE: begin
            if (rd_move) begin
               rd_state_nxt = QBR_RD_BURST;
            end
         end
         QBR_RD_BURST: begin
            if (rd_last) begin
               rd_state_nxt = QBR_RD_TAIL;
            end
         end
         QBR_RD_TAIL: begin
            // deselect at the next true edge unless another burst follows
            if (rd_move) begin
               rd_state_nxt = QBR_RD_BURST;
            end else if (k_rise) begin
               rd_state_nxt = QBR_RD_IDLE;
            end
         end
      endcase
   end

   // beat counter and output enable follow the launches
   assign rd_idx_nxt       = launch ? rd_idx_eff + 2'h1 : rd_idx_eff;
   assign read_data_oe_nxt = launch | (read_data_oe_r & (rd_state_nxt != QBR_RD_IDLE));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_pend_r       <= 1'b0;
         rd_pend_addr_r  <= '0;
         rd_base_r       <= '0;
         rd_idx_r        <= QBR_FIRST_BEAT;
         rd_state_r      <= QBR_RD_IDLE;
         read_data_out_r <= '0;
         read_data_oe_r  <= 1'b0;
      end else begin
         rd_pend_r      <= rd_take | (rd_pend_r & ~rd_move);
         rd_pend_addr_r <= rd_take ? cmd.shared_address : rd_pend_addr_r;
         rd_base_r      <= rd_base_eff;
         rd_idx_r       <= rd_idx_nxt;
         rd_state_r     <= rd_state_nxt;
         if (launch) begin
            read_data_out_r <= rd_data;
         end
         read_data_oe_r <= read_data_oe_nxt;
      end
   end

   // write engine runs beside the read engine, sharing only the phase and slot counters, the shared address bus and the array
   always_comb begin
      wr_state_nxt = wr_state_r;
      unique case (wr_state_r)
         QBR_WR_IDLE: begin
            if (wr_move && !wr_last) begin
               wr_state_nxt = QBR_WR_BURST;
            end
         end
         QBR_WR_BURST: begin
            if (wr_last) begin
               wr_state_nxt = QBR_WR_IDLE;
            end
         end
      endcase
   end

   // write address also taken from the shared bus, at the write slot
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_pend_r      <= 1'b0;
         wr_pend_addr_r <= '0;
         wr_base_r      <= '0;
         wr_idx_r       <= QBR_FIRST_BEAT;
         wr_state_r     <= QBR_WR_IDLE;
      end else begin
         wr_pend_r      <= wr_take | (wr_pend_r & ~wr_move);
         wr_pend_addr_r <= wr_take ? cmd.shared_address : wr_pend_addr_r;
         wr_base_r      <= wr_base_eff;
         wr_idx_r       <= wr_en ? wr_idx_eff + 2'h1 : wr_idx_eff;
         wr_state_r     <= wr_state_nxt;
      end
   end

   // outputs: the input clock pair is made here and shown to the controller
   assign k_clk         = ~k_phase_r;
   assign k_clk_n       = k_phase_r;
   assign read_slot     = ~slot_r;
   assign read_data_out = read_data_out_r;
   assign read_data_oe  = read_data_oe_r;

   // checks on the logic above
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // the pending slot must hold the latched address after one clock
   chk_read_addr_latch: assert property (rd_take |=> rd_pend_r && rd_pend_addr_r == $past(cmd.shared_address))
      else $error("read address not latched at read select");

   chk_slot_alternate: assert property (rd_slot |-> ##2 wr_slot ##2 rd_slot)
      else $error("read and write address slots do not alternate");

   chk_ignore_busy: assert property (rd_req && rd_pend_r && !rd_move |=> $stable(rd_pend_addr_r))
      else $error("read request overwrote a pending burst");

   chk_first_word_time: assert property (rd_take ##0 single_mode[*3] |-> launch && rd_idx_eff == 2'h0)
      else $error("first read word not launched at next input edge");

   chk_burst_four: assert property ((launch && rd_idx_eff == 2'h0 && single_mode) ##1 single_mode[*3]
                                    |-> launch && $past(launch) && $past(launch, 2) && $past(launch, 3)
                                        && rd_idx_eff == QBR_LAST_BEAT)
      else $error("single-clock read burst is not four consecutive words");

   chk_burst_wrap: assert property (launch ##1 (launch && rd_idx_eff != 2'h0)
                                    |-> rd_addr_eff[1:0] == $past(rd_addr_eff[1:0]) + 2'h1
                                        && rd_addr_eff[QBR_ADDR_W-1:2] == $past(rd_addr_eff[QBR_ADDR_W-1:2]))
      else $error("burst address did not advance linearly");

   chk_launch_data: assert property (launch |=> read_data_oe && read_data_out == $past(rd_data))
      else $error("launched word not driven on the data output");

   chk_c_mode_edge: assert property (launch && !single_mode
                                     |-> (rd_idx_eff[0] ? out_clk_n && !$past(out_clk_n)
                                                        : out_clk && !$past(out_clk)))
      else $error("read word launched off its output clock edge");

   chk_single_edge: assert property (launch && single_mode |-> rd_idx_eff[0] == k_phase_r)
      else $error("single-clock launch not on matching input edge");

   chk_hiz_after: assert property (rd_state_r == QBR_RD_TAIL && k_rise && !rd_move |=> !read_data_oe ##1 !read_data_oe)
      else $error("outputs not released after read deselect");

   chk_write_beats: assert property (wr_move |-> wr_en ##1 wr_en ##1 wr_en ##1 wr_en)
      else $error("write burst is not four consecutive beats");

   cov_single_read: cover property (rd_take ##0 single_mode[*6]);
   cov_c_mode_read: cover property (launch && !single_mode && rd_idx_eff == QBR_LAST_BEAT);
   cov_back_to_back: cover property (launch[*8]);
   cov_concurrent: cover property (launch && wr_en);

endmodule

//--- src/qbr_pkg.sv
// shared constants, types and helpers for the burst-of-four dual-rate sram port
// assumes one system clock; each sys_clk cycle is one half of the input clock pair
package qbr_pkg;

   // organisation: the wide variant is built; clear to build the narrow one
   localparam bit          QBR_WIDE         = 1'b1;
   localparam int          QBR_WIDE_WORDS   = 524288;
   localparam int          QBR_NARROW_WORDS = 1048576;
   localparam int          QBR_WORDS        = QBR_WIDE ? QBR_WIDE_WORDS : QBR_NARROW_WORDS;
   localparam int          QBR_DATA_W       = QBR_WIDE ? 36 : 18;
   localparam int          QBR_ADDR_W       = QBR_WIDE ? 19 : 20;
   localparam int          QBR_LANE_W       = 9;
   localparam int          QBR_LANES        = QBR_DATA_W / QBR_LANE_W;

   // burst of four: beat index runs 0..3
   localparam int          QBR_BURST_LEN    = 4;
   localparam logic [1:0]  QBR_FIRST_BEAT   = 2'h0;
   localparam logic [1:0]  QBR_LAST_BEAT    = 2'(QBR_BURST_LEN - 1);

   // command pins, sampled at the input clock rising edges
   typedef struct packed {
      logic                  read_sel_n;
      logic                  write_sel_n;
      logic [QBR_ADDR_W-1:0] shared_address;
   } qbr_cmd_t;

   // one write beat: lane enables and data, valid on every half-cycle
   typedef struct packed {
      logic                  lane3_write_enable_n;
      logic                  lane2_write_enable_n;
      logic                  lane1_write_enable_n;
      logic                  lane0_write_enable_n;
      logic [QBR_DATA_W-1:0] write_data_in;
   } qbr_wr_beat_t;

   typedef enum logic [2:0] {
      QBR_RD_IDLE  = 3'h1,
      QBR_RD_BURST = 3'h2,
      QBR_RD_TAIL  = 3'h4
   } qbr_rd_state_t;

   typedef enum logic [1:0] {
      QBR_WR_IDLE  = 2'h1,
      QBR_WR_BURST = 2'h2
   } qbr_wr_state_t;

   // word address of a beat: low two bits count and wrap, upper bits hold
   function automatic logic [QBR_ADDR_W-1:0] qbr_burst_addr(input logic [QBR_ADDR_W-1:0] base,
                                                             input logic [1:0]            beat);
      logic [1:0] low;
      low = base[1:0] + beat;
      return {base[QBR_ADDR_W-1:2], low};
   endfunction

endpackage

//--- src/qbr_sram_array.sv
// storage array with byte-lane write mask and combinational read
// assumes the caller presents at most one write beat per clock
`timescale 1ns/1ps
module qbr_sram_array (
   input  wire logic                           sys_clk,
   input  wire logic                           wr_en,
   input  wire logic [qbr_pkg::QBR_ADDR_W-1:0] wr_addr,
   input  wire logic [qbr_pkg::QBR_LANES-1:0]  wr_lane_mask,
   input  wire logic [qbr_pkg::QBR_DATA_W-1:0] wr_data,
   input  wire logic [qbr_pkg::QBR_ADDR_W-1:0] rd_addr,
   output      logic [qbr_pkg::QBR_DATA_W-1:0] rd_data
);
   import qbr_pkg::*;

   logic [QBR_DATA_W-1:0] mem [0:QBR_WORDS-1];

   // lane-gated write, one nine-bit lane per enable
   always_ff @(posedge sys_clk) begin
      for (int l = 0; l < QBR_LANES; l++) begin
         if (wr_en && wr_lane_mask[l]) begin
            mem[wr_addr][l*QBR_LANE_W +: QBR_LANE_W] <= wr_data[l*QBR_LANE_W +: QBR_LANE_W];
         end
      end
   end

   // read is combinational so the launch register sees the word in its own cycle
   assign rd_data = mem[rd_addr];

endmodule

//--- bench/qbr_ctrl_model.sv
// controller model: random reads and writes on their own slots, random write beats
// assumes k_clk and read_slot mark the slots; drives one nanosecond after each rising edge
`timescale 1ns/1ps
module qbr_ctrl_model (
   input  wire logic [6:0]            rd_pct,
   input  wire logic [6:0]            wr_pct,
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  k_clk,
   input  wire logic                  read_slot,
   input  wire logic                  stray,
   input  wire logic                  full_lanes,
   output      qbr_pkg::qbr_cmd_t     cmd,
   output      qbr_pkg::qbr_wr_beat_t wr_beat
);
   import qbr_pkg::*;
   // a sixteen-word window at the top of the array, so the two-bit wrap is hit often
   localparam logic [QBR_ADDR_W-1:0] WIN_BASE = '1 << 4;
   int         seed = 71295;
   int         r;
   logic [5:0] wr_hist;
   logic       rd_go;
   logic       wr_go;
   logic       beat;
   initial begin
      cmd = '{read_sel_n: 1'b1, write_sel_n: 1'b1, shared_address: WIN_BASE};
      wr_beat = '1;
      wr_hist = '0;
      forever begin
         @(posedge sys_clk);
         #1;
         r = $random(seed);
         rd_go = !rst && k_clk && read_slot && (r[7:0] % 100 < rd_pct);
         wr_go = !rst && k_clk && !read_slot && (r[15:8] % 100 < wr_pct);
         // each select on its own slot; stray ones only where they must be ignored
         cmd.read_sel_n = !(rd_go || (stray && !(k_clk && read_slot) && r[16]));
         cmd.write_sel_n = !(wr_go || (stray && !(k_clk && !read_slot) && r[17]));
         // released bus shows the inverse, so a stale address never looks valid
         cmd.shared_address = (rd_go || wr_go) ? (WIN_BASE | QBR_ADDR_W'(r[21:18])) : ~cmd.shared_address;
         // four beats, one per half-cycle, two to five cycles after the write slot
         wr_hist = {wr_hist[4:0], 1'b0};
         beat = |wr_hist[5:2];
         wr_hist[0] = wr_go;
         wr_beat.write_data_in = beat ? QBR_DATA_W'({$random(seed), $random(seed)}) : ~wr_beat.write_data_in;
         // lane enables random unless a full-word fill is asked for
         {wr_beat.lane3_write_enable_n, wr_beat.lane2_write_enable_n, wr_beat.lane1_write_enable_n,
          wr_beat.lane0_write_enable_n} = (beat && full_lanes) ? 4'h0 : 4'(r[31:28]);
      end
   end
endmodule

//--- bench/qbr_read_port_test.sv
// self-checking bench for the burst-of-four port in single-clock mode and with the output clocks running
// assumes the controller model drives command and write pins; expectations from a shadow array
`timescale 1ns/1ps
module qbr_read_port_test;
   import qbr_pkg::*;
   logic                  sys_clk;
   logic                  rst;
   logic                  out_clk;
   logic                  out_clk_n;
   logic                  k_clk;
   logic                  k_clk_n;
   logic                  read_slot;
   logic                  read_data_oe;
   logic [QBR_DATA_W-1:0] read_data_out;
   logic                  stray;
   logic                  full_lanes;
   logic                  c_mode;
   logic [6:0]            rd_pct;
   logic [6:0]            wr_pct;
   qbr_cmd_t              cmd;
   qbr_wr_beat_t          wr_beat;
   int                    failures;
   int                    checks_done;
   int                    cyc;
   int                    ph;
   int                    s;
   logic [3:0]            a;
   // shadow of the window and a sixteen-cycle history of taken commands
   logic [QBR_DATA_W-1:0] shadow [16];
   logic [QBR_DATA_W-1:0] exp_data [16];
   logic                  exp_oe [16];
   logic                  rd_tk [16];
   logic                  wr_tk [16];
   logic [3:0]            cmd_ad [16];

   qbr_read_port uut (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .cmd           (cmd),
      .wr_beat       (wr_beat),
      .out_clk       (out_clk),
      .out_clk_n     (out_clk_n),
      .k_clk         (k_clk),
      .k_clk_n       (k_clk_n),
      .read_slot     (read_slot),
      .read_data_out (read_data_out),
      .read_data_oe  (read_data_oe)
   );

   qbr_ctrl_model ctrl (
      .rd_pct     (rd_pct),
      .wr_pct     (wr_pct),
      .sys_clk    (sys_clk),
      .rst        (rst),
      .k_clk      (k_clk),
      .read_slot  (read_slot),
      .stray      (stray),
      .full_lanes (full_lanes),
      .cmd        (cmd),
      .wr_beat    (wr_beat)
   );

   task automatic check(input logic [QBR_DATA_W-1:0] got, input logic [QBR_DATA_W-1:0] want);
      checks_done++;
      if (got !== want) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // only lanes whose enable is low take the new bits
   function automatic logic [QBR_DATA_W-1:0] merge(input logic [QBR_DATA_W-1:0] old, input qbr_wr_beat_t b);
      logic [3:0] en_n;
      en_n = {b.lane3_write_enable_n, b.lane2_write_enable_n, b.lane1_write_enable_n, b.lane0_write_enable_n};
      merge = old;
      for (int k = 0; k < QBR_LANES; k++)
         if (!en_n[k]) merge[k*QBR_LANE_W +: QBR_LANE_W] = b.write_data_in[k*QBR_LANE_W +: QBR_LANE_W];
   endfunction

   task automatic tally_and_finish();
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic run(input logic [6:0] rp, input logic [6:0] wp, input logic st, input logic fl, input int n);
      @(posedge sys_clk);
      #1;
      {rd_pct, wr_pct, stray, full_lanes} = {rp, wp, st, fl};
      repeat (n) @(posedge sys_clk);
   endtask

   // reference model, sampled mid-cycle when design and controller have settled
   always @(negedge sys_clk) begin
      if (rst) begin
         cyc = 0;
         for (int i = 0; i < 16; i++)
            {exp_oe[i], rd_tk[i], wr_tk[i]} = 3'h0;
      end else begin
         ph = cyc % 4;
         check(QBR_DATA_W'({k_clk, k_clk_n, read_slot | k_clk_n}), QBR_DATA_W'({ph[0] == 0, ph[0], ph != 2}));
         check(QBR_DATA_W'(read_data_oe), QBR_DATA_W'(exp_oe[cyc % 16]));
         if (exp_oe[cyc % 16])
            check(read_data_out, exp_data[cyc % 16]);
         exp_oe[cyc % 16] = 1'b0;
         // word k launches before this cycle's write beat lands
         for (int k = 0; k < 4; k++) begin
            s = (cyc + 14 - k) % 16;
            if (rd_tk[s]) begin
               exp_data[(cyc + 1) % 16] = shadow[{cmd_ad[s][3:2], cmd_ad[s][1:0] + 2'(k)}];
               exp_oe[(cyc + 1) % 16] = 1'b1;
            end
         end
         // one beat per half-cycle into the linear burst address
         for (int k = 0; k < 4; k++) begin
            s = (cyc + 14 - k) % 16;
            a = {cmd_ad[s][3:2], cmd_ad[s][1:0] + 2'(k)};
            if (wr_tk[s])
               shadow[a] = merge(shadow[a], wr_beat);
         end
         // only a select on its own slot is taken
         rd_tk[cyc % 16] = (ph == 0) && !cmd.read_sel_n;
         wr_tk[cyc % 16] = (ph == 2) && !cmd.write_sel_n;
         cmd_ad[cyc % 16] = cmd.shared_address[3:0];
         cyc++;
      end
   end

   // output clock pair: tied high for single-clock mode, else running in step with the input pair
   // in step, the launch timing equals single-clock mode, so one reference model covers both
   always @(posedge sys_clk) begin
      #1;
      {out_clk, out_clk_n} = c_mode ? {k_clk, k_clk_n} : 2'h3;
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // phases: full-word fill, back-to-back reads with stray selects, random mix, both ports every slot, idle
   initial begin
      {rst, c_mode, stray, full_lanes} = 4'h9;
      {rd_pct, wr_pct} = {7'h00, 7'h64};
      failures = 0;
      checks_done = 0;
      repeat (12) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      run(7'h00, 7'h64, 1'b0, 1'b1, 400);
      run(7'h64, 7'h00, 1'b1, 1'b0, 200);
      run(7'h32, 7'h32, 1'b1, 1'b0, 4000);
      run(7'h64, 7'h64, 1'b0, 1'b0, 400);
      run(7'h00, 7'h00, 1'b1, 1'b0, 40);
      // output clocks start running only while no read is in flight
      c_mode = 1'b1;
      run(7'h32, 7'h32, 1'b1, 1'b0, 1000);
      run(7'h00, 7'h00, 1'b0, 1'b0, 20);
      // second reset mid-run: a write may follow in the very first write slot, a read only in the second read slot
      #1;
      rst = 1'b1;
      c_mode = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      run(7'h64, 7'h64, 1'b0, 1'b0, 200);
      run(7'h00, 7'h00, 1'b0, 1'b0, 20);
      tally_and_finish();
   end
endmodule
